// ==== hw/rexb_expansion.sv ====
// Expansion bus interface of a multiport repeater: arbitration, data, jam.
// Assumes a 20 MHz ref_clk_in and core activity inputs on the same clock.
//
// Behaviour
// - Active and acknowledged with no collision, drive NRZ repeated data.
// - During jam, data line shows 1 single-port, 0 multiport collision.
// - Data driven when ack and active, input when ack idle, else off.
// - Active device drives jam high on own port collision.
// - Jam undriven unless select or acknowledge asserted.
// - Select-in 0 at reset release picks chain or legacy arbiter mode.
// - Select-ins come from upstream select-outs and mean peer active.
// - Chain mode: select-out low when active or any select-in low.
// - Active while receiving, colliding, FIFO busy or extending to 96 bits.
// - Legacy mode: select-out asserted only as own activity request.
// - Asserted acknowledge means jam and data lines carry valid status.
// - Acknowledge open-drain two-way in chain mode, input in legacy mode.
// - Conflict low means several devices active; each jams on its own.
// - Conflict open-drain two-way in chain mode, input in legacy mode.
// - Received packet data is repeated onto the shared data line.
`timescale 1ns/1ps
`default_nettype none
`include "rexb_map.svh"

module rexb_expansion
    import rexb_pkg::*;
#(
    parameter int EXT_CYCLES = `REXB_EXT_CYCLES
) (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    input  wire rexb_core_s core_in,
    input  wire logic       chain_select_in0_n_in,
    input  wire logic       chain_select_in1_n_in,
    output var  logic       chain_select_out_n_out,
    input  wire logic       ack_n_in,
    output var  logic       ack_n_out,
    output var  logic       ack_n_oe_out,
    input  wire logic       conflict_n_in,
    output var  logic       conflict_n_out,
    output var  logic       conflict_n_oe_out,
    input  wire logic       jam_in,
    output var  logic       jam_out,
    output var  logic       jam_oe_out,
    input  wire logic       shared_data_line_in,
    output var  logic       shared_data_line_out,
    output var  logic       shared_data_line_oe_out,
    output var  logic       legacy_arbiter_mode_out,
    output var  logic       active_out,
    output var  logic       peer_data_out,
    output var  logic       peer_jam_out,
    output var  logic       peer_single_col_out,
    output var  logic       bus_conflict_out
);

    // ======================================================================
    // Input synchronisation
    // ======================================================================
    localparam int SW = 6;
    localparam logic [SW-1:0] SYNC_IDLE = 6'h3C;
    logic [SW-1:0] raw_w;
    logic [SW-1:0] syn_w;
    rexb_bus_s     bus_w;

    // Bus pins pass two flops before use; low bits idle low, high bits high.
    assign raw_w = {ack_n_in, conflict_n_in, chain_select_in0_n_in,
                    chain_select_in1_n_in, jam_in, shared_data_line_in};

    rexb_sync #(.W(SW)) u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .d_in       (raw_w),
        .rst_val_in (SYNC_IDLE),
        .q_out      (syn_w)
    );

    assign bus_w = syn_w;

    // ======================================================================
    // Mode strap
    // ======================================================================
    logic       legacy_r, legacy_nxt;
    logic [1:0] strap_cnt_r, strap_cnt_nxt;

    // The synchroniser is held in reset too, so select-in 0 is caught once, at
    // the third clock after release, when the pin level has passed both flops.
    always_comb begin
        legacy_nxt    = legacy_r;
        strap_cnt_nxt = strap_cnt_r;
        if (strap_cnt_r != `REXB_STRAP_DONE) begin
            strap_cnt_nxt = strap_cnt_r + 2'h1;
        end
        if (strap_cnt_r == `REXB_STRAP_AT) begin
            legacy_nxt = (bus_w.sel_in0_n != `REXB_STRAP_CHAIN);
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            legacy_r    <= `REXB_MODE_RST;
            strap_cnt_r <= `REXB_STRAP_RST;
        end else begin
            legacy_r    <= legacy_nxt;
            strap_cnt_r <= strap_cnt_nxt;
        end
    end

    // ======================================================================
    // Activity state machine with short-packet extension
    // ======================================================================
    rexb_state_e state_r, state_nxt;
    logic [`REXB_CNT_W-1:0] cnt_r, cnt_nxt;
    logic busy_w;
    logic active_w;

    assign busy_w = core_in.port_rx | core_in.port_col | core_in.fifo_busy;

    // Count from activity start; extend until the 96-bit minimum is met.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            REXB_IDLE: begin
                cnt_nxt = '0;
                if (busy_w) begin
                    state_nxt = REXB_ACTIVE;
                    cnt_nxt   = `REXB_CNT_W'(1);
                end
            end
            REXB_ACTIVE: begin
                if (cnt_r < `REXB_CNT_W'(EXT_CYCLES)) begin
                    cnt_nxt = cnt_r + `REXB_CNT_W'(1);
                end
                if (!busy_w) begin
                    state_nxt = (cnt_r < `REXB_CNT_W'(EXT_CYCLES)) ? REXB_EXTEND
                                                                  : REXB_IDLE;
                end
            end
            REXB_EXTEND: begin
                cnt_nxt = cnt_r + `REXB_CNT_W'(1);
                if (cnt_r >= `REXB_CNT_W'(EXT_CYCLES - 1)) begin
                    state_nxt = REXB_IDLE;
                end
            end
            default: begin
                state_nxt = REXB_IDLE;
                cnt_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= REXB_IDLE;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign active_w = busy_w | (state_r != REXB_IDLE);

    // ======================================================================
    // Bus drive
    // ======================================================================
    logic sel_n_r, sel_n_nxt;
    logic ack_oe_r, ack_oe_nxt;
    logic conf_oe_r, conf_oe_nxt;
    logic jam_r, jam_nxt, jam_oe_r, jam_oe_nxt;
    logic dat_r, dat_nxt, dat_oe_r, dat_oe_nxt;
    logic act_r;
    logic pdat_r, pjam_r, psing_r, pconf_r;
    logic ack_w, sel_w, peer_w, col_w;

    assign ack_w  = ~bus_w.ack_n;
    assign peer_w = ~bus_w.sel_in0_n | ~bus_w.sel_in1_n;
    assign sel_w  = ~sel_n_r;
    assign col_w  = core_in.port_col;

    // Compute select-out, open-drain enables, jam and data drive.
    always_comb begin
        if (legacy_nxt) begin                             // Strap acts at once.
            sel_n_nxt   = ~active_w;
            ack_oe_nxt  = 1'b0;
            conf_oe_nxt = 1'b0;
        end else begin
            sel_n_nxt   = ~(active_w | peer_w);
            ack_oe_nxt  = active_w;
            conf_oe_nxt = active_w & peer_w;
        end
        jam_oe_nxt = (sel_w | ack_w) & active_w;
        jam_nxt    = col_w;
        dat_oe_nxt = ack_w & active_w;
        if (col_w) begin
            dat_nxt = core_in.multi_col ? `REXB_COLTYPE_MULTI
                                        : `REXB_COLTYPE_SINGLE;
        end else begin
            dat_nxt = core_in.nrz_data;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_n_r   <= 1'b1;
            ack_oe_r  <= 1'b0;
            conf_oe_r <= 1'b0;
            jam_r     <= 1'b0;
            jam_oe_r  <= 1'b0;
            dat_r     <= 1'b0;
            dat_oe_r  <= 1'b0;
            act_r     <= 1'b0;
            pdat_r    <= 1'b0;
            pjam_r    <= 1'b0;
            psing_r   <= 1'b0;
            pconf_r   <= 1'b0;
        end else begin
            sel_n_r   <= sel_n_nxt;
            ack_oe_r  <= ack_oe_nxt;
            conf_oe_r <= conf_oe_nxt;
            jam_r     <= jam_nxt;
            jam_oe_r  <= jam_oe_nxt;
            dat_r     <= dat_nxt;
            dat_oe_r  <= dat_oe_nxt;
            act_r     <= active_w;
            pdat_r    <= ack_w & ~active_w & bus_w.data;
            pjam_r    <= ack_w & bus_w.jam;
            psing_r   <= ack_w & bus_w.jam & (bus_w.data == `REXB_COLTYPE_SINGLE);
            pconf_r   <= ~bus_w.conflict_n;
        end
    end

    // Open-drain pins only ever pull low.
    assign chain_select_out_n_out  = sel_n_r;
    assign ack_n_out               = 1'b0;
    assign ack_n_oe_out            = ack_oe_r;
    assign conflict_n_out          = 1'b0;
    assign conflict_n_oe_out       = conf_oe_r;
    assign jam_out                 = jam_r;
    assign jam_oe_out              = jam_oe_r;
    assign shared_data_line_out    = dat_r;
    assign shared_data_line_oe_out = dat_oe_r;
    assign legacy_arbiter_mode_out = legacy_r;
    assign active_out              = act_r;
    assign peer_data_out           = pdat_r;
    assign peer_jam_out            = pjam_r;
    assign peer_single_col_out     = psing_r;
    assign bus_conflict_out        = pconf_r;

endmodule // rexb_expansion

`default_nettype wire

// ==== inc/rexb_map.svh ====
// Constants of the repeater expansion bus block: strap encodings and timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef REXB_MAP_SVH
`define REXB_MAP_SVH

// ==========================================================================
// Strap and level encodings
// ==========================================================================
`define REXB_STRAP_CHAIN      1'b1
`define REXB_COLTYPE_SINGLE   1'b1
`define REXB_COLTYPE_MULTI    1'b0
`define REXB_MODE_RST         1'b0

// ==========================================================================
// Timing
// ==========================================================================
`define REXB_CLK_MHZ          20
`define REXB_BIT_MHZ          10
`define REXB_MIN_BITS         96
`define REXB_EXT_CYCLES       ((`REXB_MIN_BITS * `REXB_CLK_MHZ) / `REXB_BIT_MHZ)
`define REXB_CNT_W            8
`define REXB_STRAP_RST        2'h0
`define REXB_STRAP_AT         2'h2
`define REXB_STRAP_DONE       2'h3

`endif

// ==== inc/rexb_pkg.sv ====
// Types shared by the repeater expansion bus block.
// Assumes rexb_map.svh is on the include path.
`include "rexb_map.svh"

package rexb_pkg;

    // Core-side view of this repeater's own activity.
    typedef struct packed {
        logic port_rx;      // A port is receiving.
        logic port_col;     // A collision on one of our ports.
        logic multi_col;    // More than one of our ports collides.
        logic fifo_busy;    // Internal FIFO still transmitting.
        logic nrz_data;     // Repeated NRZ data bit.
    } rexb_core_s;

    // Bus-side state seen from the outside.
    typedef struct packed {
        logic ack_n;
        logic conflict_n;
        logic sel_in0_n;
        logic sel_in1_n;
        logic jam;
        logic data;
    } rexb_bus_s;

    typedef enum logic [2:0] {
        REXB_IDLE   = 3'b001,
        REXB_ACTIVE = 3'b010,
        REXB_EXTEND = 3'b100
    } rexb_state_e;

endpackage

// ==== hw/rexb_sync.sv ====
// Two-flop synchroniser bank for expansion-bus inputs.
// Assumes inputs asynchronous to ref_clk_in; reset is asynchronous high.
`timescale 1ns/1ps
`default_nettype none

module rexb_sync #(
    parameter int W = 6
) (
    input  wire logic         ref_clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] d_in,
    input  wire logic [W-1:0] rst_val_in,
    output var  logic [W-1:0] q_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // Reset makes q_out show the rst_val_in levels; rst_val_in is constant in use.
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge ref_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_r[g] <= 1'b1;
                    q_r[g]    <= 1'b1;
                end else begin
                    meta_r[g] <= d_in[g] ^ ~rst_val_in[g];
                    q_r[g]    <= meta_r[g];
                end
            end
            assign q_out[g] = q_r[g] ^ ~rst_val_in[g];
        end
    endgenerate

endmodule // rexb_sync

`default_nettype wire

// ==== tb/rexb_expansion_monitor.sv ====
// Checker of the expansion bus block, bound to its ports.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module rexb_expansion_monitor
    import rexb_pkg::*;
#(
    parameter int EXT_CYCLES = 8
) (
    input wire logic       ref_clk_in,
    input wire logic       rst_in,
    input wire rexb_core_s core_in,
    input wire logic       chain_select_in0_n_in,
    input wire logic       chain_select_out_n_out,
    input wire logic       ack_n_in,
    input wire logic       ack_n_oe_out,
    input wire logic       conflict_n_oe_out,
    input wire logic       jam_out,
    input wire logic       jam_oe_out,
    input wire logic       shared_data_line_out,
    input wire logic       shared_data_line_oe_out,
    input wire logic       legacy_arbiter_mode_out,
    input wire logic       active_out
);
    // ========================================================================
    // Activity run length
    // ========================================================================
    int unsigned run_r;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // Counts consecutive cycles of activity.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) run_r <= '0;
        else run_r <= active_out ? run_r + 32'h1 : '0;
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    a_sel_chain: assert property (!legacy_arbiter_mode_out && !$past(rst_in, 3)
        && !$past(chain_select_in0_n_in, 3) |-> !chain_select_out_n_out)
        else $error("select out not asserted for low select in");
    a_sel_legacy: assert property (legacy_arbiter_mode_out
        |-> chain_select_out_n_out == !active_out) else $error("request differs from activity");
    a_legacy_nodrive: assert property (legacy_arbiter_mode_out
        |-> !ack_n_oe_out && !conflict_n_oe_out) else $error("open-drain driven in legacy mode");
    a_jam_drive: assert property ($rose(core_in.port_col)
        |-> ##[1:2] jam_oe_out && jam_out) else $error("jam not driven on collision");
    a_jam_off: assert property (jam_oe_out
        |-> !chain_select_out_n_out || !$past(ack_n_in, 3)) else $error("jam driven while idle");
    a_col_type: assert property (jam_out && jam_oe_out && shared_data_line_oe_out
        |-> shared_data_line_out == !$past(core_in.multi_col)) else $error("wrong collision type");
    a_data_nrz: assert property (shared_data_line_oe_out && !jam_out
        && $past(core_in.port_rx) |-> shared_data_line_out == $past(core_in.nrz_data))
        else $error("data line differs from repeated data");
    a_data_oe: assert property (shared_data_line_oe_out
        |-> active_out && !$past(ack_n_in, 3)) else $error("data driven without grant");
    a_conf_drive: assert property (!legacy_arbiter_mode_out && active_out
        && !$past(rst_in, 3) && !$past(chain_select_in0_n_in, 3) |-> conflict_n_oe_out)
        else $error("conflict not pulled");
    a_ext_min: assert property ($fell(active_out)
        |-> $past(run_r) >= EXT_CYCLES - 1) else $error("activity shorter than minimum");

    // Main scenarios reached.
    c_jam: cover property ($rose(jam_out));
    c_conf: cover property ($rose(conflict_n_oe_out));
    c_legacy: cover property ($rose(legacy_arbiter_mode_out));
endmodule // rexb_expansion_monitor
`default_nettype wire

// ==== tb/rexb_bus_model.sv ====
// Peer devices and board wiring at the far side of the expansion bus.
// Assumes pull-ups on the open-drain lines, pull-downs on jam and data.
`timescale 1ns/1ps
`default_nettype none

module rexb_bus_model (
    input  wire logic ack_oe_in,
    input  wire logic conf_oe_in,
    input  wire logic jam_oe_in,
    input  wire logic jam_d_in,
    input  wire logic dat_oe_in,
    input  wire logic dat_d_in,
    input  wire logic peer_act_in,
    input  wire logic peer_jam_in,
    input  wire logic peer_dat_in,
    output wire logic ack_n_out,
    output wire logic conf_n_out,
    output wire logic jam_out,
    output wire logic dat_out
);
    // ========================================================================
    // Line resolution
    // ========================================================================
    // Open-drain lines go low when any party pulls; a busy peer flags conflict while ack_oe_in is set.
    assign ack_n_out = ~(ack_oe_in | peer_act_in);
    assign conf_n_out = ~(conf_oe_in | (peer_act_in & ack_oe_in));
    // Undriven lines fall to the pull-down level.
    assign jam_out = jam_oe_in ? jam_d_in : (peer_act_in & peer_jam_in);
    assign dat_out = dat_oe_in ? dat_d_in : (peer_act_in & peer_dat_in);
endmodule // rexb_bus_model
`default_nettype wire

// ==== tb/tb_repeater_expansion_bus.sv ====
// Testbench of the expansion bus block against a peer bus model.
// Assumes the package, design, checker and bus model compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_repeater_expansion_bus
    import rexb_pkg::*;
;
    localparam int EXT = 8;
    logic       ref_clk_in = 1'b0;
    logic       rst_in = 1'b1;
    rexb_core_s core_in = '0;
    logic       chain_select_in0_n_in = 1'b1;
    logic       chain_select_in1_n_in = 1'b0;
    logic       peer_act = 1'b0;
    logic       peer_jam = 1'b0;
    logic       peer_dat = 1'b0;
    logic       ack_n_in, conflict_n_in, jam_in, shared_data_line_in;
    logic       chain_select_out_n_out, ack_n_out, ack_n_oe_out, conflict_n_out;
    logic       conflict_n_oe_out, jam_out, jam_oe_out, shared_data_line_out;
    logic       shared_data_line_oe_out, legacy_arbiter_mode_out, active_out;
    logic       peer_data_out, peer_jam_out, peer_single_col_out, bus_conflict_out;
    int         mismatches = 0;
    int         checks = 0;
    int         cyc_cnt = 0;

    // ========================================================================
    // Clock, design and far side
    // ========================================================================
    always #25 ref_clk_in = ~ref_clk_in;
    rexb_expansion #(.EXT_CYCLES(EXT)) dut (.*);
    rexb_bus_model bus (.ack_oe_in(ack_n_oe_out), .conf_oe_in(conflict_n_oe_out),
        .jam_oe_in(jam_oe_out), .jam_d_in(jam_out), .dat_oe_in(shared_data_line_oe_out),
        .dat_d_in(shared_data_line_out), .peer_act_in(peer_act), .peer_jam_in(peer_jam),
        .peer_dat_in(peer_dat), .ack_n_out(ack_n_in), .conf_n_out(conflict_n_in),
        .jam_out(jam_in), .dat_out(shared_data_line_in));

    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask

    task automatic chk(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
            mismatches++;
        end
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Resets at a falling clock edge with the mode strap held past release.
    task automatic do_reset(input logic strap);
        rst_in = 1'b1;
        chain_select_in0_n_in = strap;
        chain_select_in1_n_in = ~strap;
        cyc(20);
        rst_in = 1'b0;
        cyc(4);
        chain_select_in0_n_in = 1'b1;
        chain_select_in1_n_in = 1'b1;
        chk("mode", ~strap, legacy_arbiter_mode_out);
    endtask

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_ext();
        int n;
        n = 0;
        core_in.port_rx = 1'b1;
        cyc(1);
        core_in.port_rx = 1'b0;
        n += active_out;
        repeat (EXT + 4) begin
            cyc(1);
            n += active_out;
        end
        chk("ext_len", 1'b1, n >= EXT && n <= EXT + 1);
    endtask

    task automatic t_rx();
        core_in.port_rx = 1'b1;
        for (int i = 0; i < 12; i++) begin
            cyc(1);
            if (i > 4) chk("dat_out", core_in.nrz_data, shared_data_line_out);
            if (i > 4) chk("dat_oe", 1'b1, shared_data_line_oe_out);
            if (i > 4) chk("ack_oe", 1'b1, ack_n_oe_out);
            core_in.nrz_data = i[0] ^ i[1];
        end
        core_in = '0;
        cyc(EXT + 4);
    endtask

    task automatic t_col();
        core_in.port_rx = 1'b1;
        core_in.port_col = 1'b1;
        cyc(6);
        chk("jam", 1'b1, jam_out & jam_oe_out);
        chk("single", 1'b1, shared_data_line_out);
        core_in.multi_col = 1'b1;
        cyc(2);
        chk("multi", 1'b0, shared_data_line_out);
        core_in = '0;
        cyc(EXT + 4);
        chk("jam_off", 1'b0, jam_oe_out);
    endtask

    task automatic t_peer();
        chain_select_in0_n_in = 1'b0;
        peer_act = 1'b1;
        peer_dat = 1'b1;
        cyc(4);
        chk("sel_out", 1'b0, chain_select_out_n_out);
        chk("peer_dat", 1'b1, peer_data_out);
        peer_dat = 1'b0;
        cyc(4);
        chk("peer_dat0", 1'b0, peer_data_out);
        peer_jam = 1'b1;
        peer_dat = 1'b1;
        cyc(4);
        chk("peer_single", 1'b1, peer_single_col_out & peer_jam_out);
        peer_dat = 1'b0;
        cyc(4);
        chk("peer_multi", 1'b0, peer_single_col_out);
        chk("peer_jam", 1'b1, peer_jam_out);
        peer_jam = 1'b0;
        core_in.port_rx = 1'b1;
        cyc(2);
        chk("conf_oe", 1'b1, conflict_n_oe_out);
        chk("od_low", 1'b0, ack_n_out | conflict_n_out);
        cyc(3);
        chk("conflict", 1'b1, bus_conflict_out);
        core_in = '0;
        peer_act = 1'b0;
        chain_select_in0_n_in = 1'b1;
        cyc(EXT + 4);
    endtask

    task automatic t_legacy();
        do_reset(1'b0);
        core_in.port_rx = 1'b1;
        cyc(3);
        chk("req", 1'b0, chain_select_out_n_out);
        chk("od_off", 1'b0, ack_n_oe_out | conflict_n_oe_out);
        peer_act = 1'b1;
        cyc(4);
        chk("dat_oe", 1'b1, shared_data_line_oe_out);
        core_in = '0;
        peer_act = 1'b0;
        cyc(EXT + 4);
        chk("req_off", 1'b1, chain_select_out_n_out);
    endtask

    // Stops a hung run.
    always @(posedge ref_clk_in) begin
        cyc_cnt++;
        if (cyc_cnt > 5000) begin
            mismatches++;
            print_verdict();
        end
    end

    // Main sequence.
    initial begin
        do_reset(1'b1);
        t_ext();
        t_rx();
        t_col();
        t_peer();
        t_legacy();
        print_verdict();
    end
endmodule // tb_repeater_expansion_bus

bind rexb_expansion rexb_expansion_monitor #(.EXT_CYCLES(EXT_CYCLES)) mon (.*);
`default_nettype wire
